// ### psmi_ctrl_model.sv
// Purpose: Controller model that drives the request channel pins and both link clocks.
// Assumes: The bench changes mode_n_in and sym_in only between link clock edges.
// Notes: The receive clock is locked in phase to the transmit clock, as in management mode.
module psmi_ctrl_model (
  input wire logic mode_n_in, // Requested mode, low selects management.
  input wire logic [2:0] sym_in, // Requested symbol or command.
  output logic xmit_clock_out, // Transmit link clock, 400 ns.
  output logic recv_clock_out, // Receive link clock.
  output logic mgmt_mode_req_n_out, // Mode request pin.
  output logic [2:0] req_sym_out // Request symbol pins.
);
  timeunit 1ns;
  timeprecision 1ns;

  // Free-running link clock; the receive clock follows it in phase.
  initial begin
    xmit_clock_out = 1'b0;
    forever #200 xmit_clock_out = ~xmit_clock_out;
  end
  assign recv_clock_out = xmit_clock_out;

  // Pins start in MAC mode with silence and change only on the falling edge,
  // so each request is stable around the rise that captures it.
  initial begin
    mgmt_mode_req_n_out = 1'b1;
    req_sym_out = 3'h6;
  end
  always @(negedge xmit_clock_out) begin
    mgmt_mode_req_n_out <= mode_n_in;
    req_sym_out <= sym_in;
  end
endmodule

// ### psmi_nack.sv
// Purpose: Serialises the all-zero response byte behind a NACK.
// Assumes: tick_in pulses once per receive clock period.
// Notes: Abort wins over start and over a tick in the same cycle.
module psmi_nack
  import psmi_pkg::*;
(
  input wire logic ref_clk_in, // Core clock.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic start_in, // Starts a response byte.
  input wire logic abort_in, // Cancels the byte at once.
  input wire logic tick_in, // Receive clock update pulse.
  output logic busy_out, // Byte in progress.
  output logic bit_out // Bit to show at the next tick.
);

  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic busy_d;
  logic last_w;

  // Stop bit is the last of the byte; all earlier bits are low.
  assign last_w = (cnt_q == 4'(NACK_TOTAL_BITS - 1));
  assign bit_out = (cnt_q >= 4'(NACK_LOW_BITS));
  assign busy_d = abort_in ? 1'b0 : start_in ? 1'b1 : (tick_in && last_w) ? 1'b0 : busy_out;
  assign cnt_d = (abort_in || start_in) ? 4'h0 : (tick_in && busy_out) ? cnt_q + 4'h1 : cnt_q;

  // Counts bit periods while a byte is in progress.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_out <= 1'b0;
      cnt_q <= 4'h0;
    end else begin
      busy_out <= busy_d;
      cnt_q <= cnt_d;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  // The byte lasts exactly ten ticks unless aborted.
  property p_nack_len;
    (busy_out && tick_in && !abort_in && cnt_q == 4'h9) |=> !busy_out;
  endproperty
  a_nack_len: assert property (p_nack_len) else $error("NACK byte did not end after stop bit"); // [R25]

  // Low bits hold for the first nine periods.
  property p_nack_low;
    (busy_out && cnt_q < 4'h9) |-> !bit_out;
  endproperty
  a_nack_low: assert property (p_nack_low) else $error("NACK data bit not low"); // [R25]

endmodule

// ### psmi_phy_if.sv
// Purpose: Physical side of the serial symbol request and indication channels with management commands.
// Assumes: Link clocks and pins are asynchronous to ref_clk_in and at least four times slower.
// Notes: Requests are taken at the transmit clock rise, indications change at the receive clock fall.
// Behaviour
// [R1] Management mode codes: 111 reset, 101 loopback off, 011 transmitter on, 00x data/idle.
// [R2] Only reset, loopback off, transmitter on, idle run; serial data gets NACK.
// [R3] MAC mode codes: 000 zero, 001 one, 10X non-data, 01X pad-idle, 11X silence.
// [R4] Controller sends non-data symbols only in pairs.
// [R5] Mode indication high in MAC mode, low in management mode or on error.
// [R6] Indication lines change synchronously with the receive clock.
// [R7] Management indications: 10x NACK, 01x ACK, 001 idle, 111 physical error.
// [R8] During serial data response bit0 carries data, bits 2..1 carry NACK.
// [R9] MAC indications: 000 zero, 001 one, 10X non-data, 11X silence, 01X bad.
// [R10] Jabber inhibit is reported as the physical layer error code.
// [R11] Serial data command returns NACK with an all-zero framed response byte.
// [R12] Reset, loopback off or transmitter on aborts a running NACK response.
// [R13] Reset command enables loopback, disables transmitter, clears jabber, answers ACK.
// [R14] Hardware reset pin is asynchronous, active high, same effect as reset command.
// [R15] Released in management mode, the device waits for a MAC-to-management transition.
// [R16] Controller releases reset in MAC mode or visits MAC mode first.
// [R17] Loopback routes the internal transmit symbol into the recovery path.
// [R18] Loopback entered only by reset, left only by loopback off, which gets ACK.
// [R19] Full duplex: looped MAC symbols are reported while being sent.
// [R20] Transmitter stays disabled until transmitter on, which is acknowledged with ACK.
// [R21] Controller sends loopback off, transmitter on, then returns to MAC mode.
// [R22] Idle and invalid commands return the idle response.
// [R23] ACK appears within two clocks; controller holds the command until seen.
// [R24] Silence for seventeen clocks before mode indication goes low.
// [R25] Response byte: bit0 low nine clocks, then high one clock.
// [R26] Request lines are registered on the transmit clock before decoding.
module psmi_phy_if
  import psmi_pkg::*;
(
  input wire logic ref_clk_in, // Core clock, 20 MHz.
  input wire logic rst_n_in, // System reset, active low.
  input wire logic hw_reset_in, // Reset pin, active high.
  input wire logic xmit_clock_in, // Transmit clock from the controller side.
  input wire logic recv_clock_in, // Receive clock from clock recovery.
  input wire logic mgmt_mode_req_n_in, // Mode request, low selects management.
  input wire logic req_sym_bit2_in, // Request symbol bit 2.
  input wire logic req_sym_bit1_in, // Request symbol bit 1.
  input wire logic req_sym_bit0_in, // Request symbol bit 0.
  input wire logic [2:0] line_rx_sym_in, // Symbol recovered from the line receiver.
  input wire logic jabber_in, // Jabber inhibit condition.
  output logic mgmt_mode_ind_n_out, // Mode indication, low in management or error.
  output logic ind_sym_bit2_out, // Indication symbol bit 2.
  output logic ind_sym_bit1_out, // Indication symbol bit 1.
  output logic ind_sym_bit0_out, // Indication symbol bit 0.
  output logic [2:0] tx_sym_out, // Internal transmit symbol before the buffers.
  output logic xmit_disable_out, // Transmitter disabled.
  output logic xmit_out_en_out, // Transmitter output buffers enabled.
  output logic loopback_out, // Internal loopback active.
  output logic jabber_clear_out // Clears the jabber inhibit timer.
);

  logic arst_n;
  logic [1:0] clk_s;
  logic [1:0] clk_d_q;
  logic [3:0] req_s;
  logic [3:0] misc_s;
  logic tx_tick;
  logic rx_tick;
  logic jab_s;
  logic [2:0] line_s;
  logic [2:0] req_q;
  logic mode_n_q;
  logic req_new_q;
  psmi_mode_t mode_q;
  psmi_mode_t mode_d;
  logic [4:0] wait_q;
  logic [4:0] wait_d;
  logic cmd_hit;
  logic hit_reset;
  logic hit_dis;
  logic hit_en;
  logic hit_sm;
  logic prev_sm_q;
  logic loopback_q;
  logic tx_en_q;
  logic jab_clr_q;
  logic nack_busy;
  logic nack_bit;
  logic nack_abort;
  logic [2:0] lb_sym;
  logic [2:0] rec_sym;
  logic [2:0] mgmt_sym;
  logic [2:0] resp_sym;
  logic resp_ind_n;
  logic [2:0] ind_q;
  logic ind_n_q;
  logic [2:0] tx_sym_q;

  // The reset pin acts without the clock, like the system reset.
  assign arst_n = rst_n_in & ~hw_reset_in; // [R14]

  // Both link clocks are sampled as ordinary pins.
  psmi_sync #(.WIDTH(2)) u_clk_sync (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n),
    .d_in({xmit_clock_in, recv_clock_in}),
    .q_out(clk_s)
  );

  // Request pins pass two flops before capture.
  psmi_sync #(.WIDTH(4)) u_req_sync (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n),
    .d_in({mgmt_mode_req_n_in, req_sym_bit2_in, req_sym_bit1_in, req_sym_bit0_in}),
    .q_out(req_s)
  );

  // Line symbol and jabber condition pass two flops as well.
  psmi_sync #(.WIDTH(4)) u_misc_sync (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n),
    .d_in({jabber_in, line_rx_sym_in}),
    .q_out(misc_s)
  );

  assign jab_s = misc_s[3];
  assign line_s = misc_s[2:0];

  // Transmit clock rise takes requests; receive clock fall moves indications.
  assign tx_tick = clk_s[1] & ~clk_d_q[1];
  assign rx_tick = ~clk_s[0] & clk_d_q[0]; // [R6]

  // Edge detector history.
  always_ff @(posedge ref_clk_in or negedge arst_n) begin
    if (!arst_n) begin
      clk_d_q <= 2'h0;
    end else begin
      clk_d_q <= clk_s;
    end
  end

  // Registers the request word on the transmit clock so no half-changed code is decoded.
  always_ff @(posedge ref_clk_in or negedge arst_n) begin
    if (!arst_n) begin
      req_q <= REQ_IDLE;
      mode_n_q <= 1'b1;
      req_new_q <= 1'b0;
    end else begin
      req_new_q <= tx_tick; // [R26]
      if (tx_tick) begin
        req_q <= req_s[2:0]; // [R26]
        mode_n_q <= req_s[3];
      end
    end
  end

  // Mode sequencing; after reset the device waits for MAC mode before commands count.
  always_comb begin
    mode_d = mode_q;
    wait_d = wait_q;
    unique case (mode_q)
      PSMI_HOLD: begin
        if (req_new_q && mode_n_q) begin
          mode_d = PSMI_MAC; // [R15]
        end
      end
      PSMI_MAC: begin
        if (req_new_q && !mode_n_q) begin
          mode_d = PSMI_WAIT;
          wait_d = 5'h0;
        end
      end
      PSMI_WAIT: begin
        if (req_new_q && mode_n_q) begin
          mode_d = PSMI_MAC;
        end else if (rx_tick) begin
          wait_d = wait_q + 5'h1;
          // The indication register shows the new mode one fall later, so the switch comes one fall early.
          if (wait_q == 5'(MGMT_ENTRY_TICKS - 2)) begin
            mode_d = PSMI_MGMT; // [R24]
          end
        end
      end
      PSMI_MGMT: begin
        if (req_new_q && mode_n_q) begin
          mode_d = PSMI_MAC;
        end
      end
    endcase
  end

  // Mode state register.
  always_ff @(posedge ref_clk_in or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= PSMI_HOLD;
      wait_q <= 5'h0;
    end else begin
      mode_q <= mode_d;
      wait_q <= wait_d;
    end
  end

  // Command decode, only in management mode on a fresh request word.
  assign cmd_hit = req_new_q && !mode_n_q && (mode_q == PSMI_MGMT);
  assign hit_reset = cmd_hit && (req_q == REQ_RESET); // [R1]
  assign hit_dis = cmd_hit && (req_q == REQ_DIS_LB); // [R1]
  assign hit_en = cmd_hit && (req_q == REQ_EN_TX); // [R1]
  assign hit_sm = cmd_hit && (req_q == REQ_SERIAL_MGMT_DATA_CMD) && !prev_sm_q && !nack_busy; // [R2]
  assign nack_abort = hit_reset | hit_dis | hit_en; // [R12]

  // Loopback, transmitter enable and jabber clear follow the commands.
  always_ff @(posedge ref_clk_in or negedge arst_n) begin
    if (!arst_n) begin
      loopback_q <= 1'b1;
      tx_en_q <= 1'b0;
      jab_clr_q <= 1'b1;
      prev_sm_q <= 1'b0;
    end else begin
      jab_clr_q <= hit_reset; // [R13]
      if (cmd_hit) begin
        prev_sm_q <= (req_q == REQ_SERIAL_MGMT_DATA_CMD);
      end
      if (hit_reset) begin
        loopback_q <= 1'b1; // [R13] [R18]
        tx_en_q <= 1'b0; // [R13] [R20]
      end else begin
        if (hit_dis) begin
          loopback_q <= 1'b0; // [R18]
        end
        if (hit_en) begin
          tx_en_q <= 1'b1; // [R20]
        end
      end
    end
  end

  // Response byte generator behind NACK.
  psmi_nack u_nack (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n),
    .start_in(hit_sm),
    .abort_in(nack_abort),
    .tick_in(rx_tick),
    .busy_out(nack_busy),
    .bit_out(nack_bit)
  );

  // Looped symbol as recovered from the internal transmit signal; pad-idle recovers as data.
  assign lb_sym = (tx_sym_q[2:1] == MAC_DATA) ? tx_sym_q :
                  (tx_sym_q[2:1] == MAC_NONDATA) ? IND_NONDATA :
                  (tx_sym_q[2:1] == MAC_PAD) ? IND_ONE : IND_SILENCE; // [R3]
  assign rec_sym = loopback_q ? lb_sym : line_s; // [R17] [R19]

  // Management response; NACK carries the serial data bit in bit0.
  assign mgmt_sym = nack_busy ? {IND_NACK, nack_bit} : // [R8] [R11]
                    (req_q == REQ_RESET || req_q == REQ_DIS_LB || req_q == REQ_EN_TX) ?
                    {IND_ACK, 1'b1} : IND_IDLE; // [R7] [R22] [R23]

  // Output selection by mode, with the jabber error taking priority.
  assign resp_sym = jab_s ? IND_PHY_ERR : // [R10]
                    (mode_q == PSMI_MGMT) ? mgmt_sym :
                    (mode_q == PSMI_MAC) ? rec_sym : IND_SILENCE; // [R9] [R24]
  assign resp_ind_n = ~jab_s && (mode_q != PSMI_MGMT); // [R5]

  // Indication lines move only on the receive clock fall.
  always_ff @(posedge ref_clk_in or negedge arst_n) begin
    if (!arst_n) begin
      ind_q <= IND_SILENCE;
      ind_n_q <= 1'b1;
    end else if (rx_tick) begin
      ind_q <= resp_sym; // [R6]
      ind_n_q <= resp_ind_n; // [R5]
    end
  end

  // Internal transmit symbol; silence outside MAC mode.
  always_ff @(posedge ref_clk_in or negedge arst_n) begin
    if (!arst_n) begin
      tx_sym_q <= {MAC_SILENCE, 1'b0};
    end else if (req_new_q) begin
      tx_sym_q <= (mode_n_q && mode_q != PSMI_HOLD) ? req_q : {MAC_SILENCE, 1'b0}; // [R19]
    end
  end

  assign mgmt_mode_ind_n_out = ind_n_q;
  assign ind_sym_bit2_out = ind_q[2];
  assign ind_sym_bit1_out = ind_q[1];
  assign ind_sym_bit0_out = ind_q[0];
  assign tx_sym_out = tx_sym_q;
  assign xmit_disable_out = ~tx_en_q; // [R20]
  assign xmit_out_en_out = tx_en_q;
  assign loopback_out = loopback_q;
  assign jabber_clear_out = jab_clr_q;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n);

  // Indication update follows a receive clock fall.
  sequence s_rx_update;
    rx_tick ##1 1'b1;
  endsequence

  property p_sync_rx;
    $changed(ind_q) |-> $past(rx_tick);
  endproperty
  a_sync_rx: assert property (p_sync_rx) else $error("Indication changed off the receive clock"); // [R6]

  property p_mac_ind;
    (rx_tick && mode_q == PSMI_MAC && !jab_s) |=> ind_n_q;
  endproperty
  a_mac_ind: assert property (p_mac_ind) else $error("Mode indication low in MAC mode"); // [R5]

  property p_jabber;
    (rx_tick && jab_s) |=> (ind_q == IND_PHY_ERR && !ind_n_q);
  endproperty
  a_jabber: assert property (p_jabber) else $error("Jabber not reported as error"); // [R10]

  property p_reset_cmd;
    hit_reset |=> (loopback_q && !tx_en_q && jab_clr_q);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("Reset command effects missing"); // [R13]

  property p_lb_entry;
    $rose(loopback_q) |-> $past(hit_reset);
  endproperty
  a_lb_entry: assert property (p_lb_entry) else $error("Loopback entered without reset"); // [R18]

  property p_tx_entry;
    $rose(tx_en_q) |-> $past(hit_en);
  endproperty
  a_tx_entry: assert property (p_tx_entry) else $error("Transmitter enabled without command"); // [R20]

  property p_abort;
    nack_abort |=> !nack_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("NACK response not aborted"); // [R12]

  property p_wait_silence;
    (rx_tick && mode_q == PSMI_WAIT && !jab_s) |=> (ind_q == IND_SILENCE && ind_n_q);
  endproperty
  a_wait_silence: assert property (p_wait_silence) else $error("No silence before management mode"); // [R24]

  property p_nack_code;
    (rx_tick && nack_busy && mode_q == PSMI_MGMT && !jab_s) ##1 1'b1 |-> ind_q[2:1] == IND_NACK;
  endproperty
  a_nack_code: assert property (p_nack_code) else $error("NACK code missing during response"); // [R8]

  property p_idle_resp;
    (rx_tick && mode_q == PSMI_MGMT && !jab_s && !nack_busy && req_q == REQ_IDLE) |=> ind_q == IND_IDLE;
  endproperty
  a_idle_resp: assert property (p_idle_resp) else $error("Idle response missing"); // [R22]

  property p_hold_cmd;
    (mode_q == PSMI_HOLD && !jab_s) ##0 s_rx_update |-> (loopback_q && !tx_en_q && ind_n_q);
  endproperty
  a_hold_cmd: assert property (p_hold_cmd) else $error("Command taken while held after reset"); // [R15]

endmodule

// ### psmi_pkg.sv
// Purpose: Shared codes, states and counts for the serial symbol and management interface.
// Assumes: Symbol codes are written as {bit2, bit1, bit0}.
// Notes: Link clock rates range from 1.0 to 5 MHz; the core clock is 20 MHz.
package psmi_pkg;

  // Management request codes.
  localparam logic [2:0] REQ_RESET = 3'h7;
  localparam logic [2:0] REQ_DIS_LB = 3'h5;
  localparam logic [2:0] REQ_EN_TX = 3'h3;
  localparam logic [2:0] REQ_SERIAL_MGMT_DATA_CMD = 3'h0;
  localparam logic [2:0] REQ_IDLE = 3'h1;

  // MAC request classes held in bits 2 and 1.
  localparam logic [1:0] MAC_DATA = 2'h0;
  localparam logic [1:0] MAC_PAD = 2'h1;
  localparam logic [1:0] MAC_NONDATA = 2'h2;
  localparam logic [1:0] MAC_SILENCE = 2'h3;

  // MAC indication codes.
  localparam logic [2:0] IND_ONE = 3'h1;
  localparam logic [2:0] IND_NONDATA = 3'h4;
  localparam logic [2:0] IND_SILENCE = 3'h6;
  localparam logic [2:0] IND_BAD = 3'h2;

  // Management indication codes; NACK and ACK fill bits 2 and 1 only.
  localparam logic [1:0] IND_NACK = 2'h2;
  localparam logic [1:0] IND_ACK = 2'h1;
  localparam logic [2:0] IND_IDLE = 3'h1;
  localparam logic [2:0] IND_PHY_ERR = 3'h7;

  // Receive clock periods of silence before management mode is shown.
  localparam int MGMT_ENTRY_TICKS = 17;
  // Bit periods of the response byte: start plus eight zeros, then stop.
  localparam int NACK_LOW_BITS = 9;
  localparam int NACK_TOTAL_BITS = 10;

  // Core clock rate.
  localparam int REF_CLK_HZ = 20000000;

  // Operating mode of the request channel.
  typedef enum logic [1:0] {
    PSMI_HOLD = 2'b00,
    PSMI_MAC = 2'b01,
    PSMI_WAIT = 2'b10,
    PSMI_MGMT = 2'b11
  } psmi_mode_t;

endpackage

// ### psmi_sync.sv
// Purpose: Two-flop synchroniser for a group of pins.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage is visible outside.
module psmi_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_in, // Core clock.
  input wire logic arst_n_in, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] d_in, // Pin levels.
  output logic [WIDTH-1:0] q_out // Synchronised levels.
);

  logic [WIDTH-1:0] meta_q;

  // The first stage feeds the second stage only.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= '0;
      q_out <= '0;
    end else begin
      meta_q <= d_in;
      q_out <= meta_q;
    end
  end

endmodule

// ### test_psmi_phy_if.sv
// Purpose: Self-checking bench for the serial symbol and management interface.
// Assumes: Link clocks of 400 ns in phase; the core clock runs at 20 MHz.
// Notes: Indications are sampled 130 ns after a link rise, between two updates.
module test_psmi_phy_if import psmi_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in, rst_n_in, hw_reset_in, jabber_in, mode_n, xclk, rclk, req_n;
  logic ind_n, i2, i1, i0, xdis, xen, lb, jclr;
  logic [2:0] sym, req_sym, line_rx, tx_sym, e, m;
  logic [2:0] codes [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  int failures, total_checks, seed, n, i, jc_cnt, jc0;
  wire [2:0] ind = {i2, i1, i0};

  psmi_ctrl_model ctrl (.mode_n_in(mode_n), .sym_in(sym), .xmit_clock_out(xclk), .recv_clock_out(rclk),
    .mgmt_mode_req_n_out(req_n), .req_sym_out(req_sym));
  psmi_phy_if uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .hw_reset_in(hw_reset_in),
    .xmit_clock_in(xclk), .recv_clock_in(rclk), .mgmt_mode_req_n_in(req_n), .req_sym_bit2_in(req_sym[2]),
    .req_sym_bit1_in(req_sym[1]), .req_sym_bit0_in(req_sym[0]), .line_rx_sym_in(line_rx),
    .jabber_in(jabber_in), .mgmt_mode_ind_n_out(ind_n), .ind_sym_bit2_out(i2), .ind_sym_bit1_out(i1),
    .ind_sym_bit0_out(i0), .tx_sym_out(tx_sym), .xmit_disable_out(xdis), .xmit_out_en_out(xen),
    .loopback_out(lb), .jabber_clear_out(jclr));

  // Core clock.
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // Counts jabber timer clear pulses; only this process writes the count.
  always @(posedge ref_clk_in) begin
    if (jclr === 1'b1) begin
      jc_cnt <= jc_cnt + 1;
    end
  end

  // Looped pad-idle reads back as a one; other request codes map directly.
  function automatic logic [2:0] loop_exp(input logic [2:0] s);
    return (s[2:1] == MAC_PAD) ? IND_ONE : s;
  endfunction

  // Bit 0 is a don't-care unless the symbol is a zero or a one.
  function automatic logic [2:0] msk(input logic [2:0] s);
    return (s[2] | s[1]) ? 3'h6 : 3'h7;
  endfunction

  task automatic check(input logic [2:0] seen, input logic [2:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: seen %b expected %b", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge xclk);
    repeat (3) @(posedge ref_clk_in);
    #5;
  endtask

  task automatic wait_nack;
    n = 0;
    while (ind !== {IND_NACK, 1'b0} && n < 8) begin
      tick(1);
      n++;
    end
  endtask

  task automatic enter(input logic [2:0] cmd);
    mode_n = 1'b0;
    sym = cmd;
    n = 0;
    // The first update after the request still shows the last MAC symbol.
    tick(2);
    while (ind_n === 1'b1 && n < 40) begin
      check(ind & 3'h6, IND_SILENCE, "silence while entering");
      tick(1);
      n++;
    end
    check({2'h0, n >= 16 && n <= 17}, 3'h1, "entry delay");
    check({2'h0, ind_n}, 3'h0, "mode indication low");
  endtask

  // Random MAC traffic; delimiters are left out, so no lone one is sent.
  task automatic mac_run(input logic use_line);
    for (i = 0; i < 8; i++) begin
      sym = 3'($random(seed));
      if (sym[2:1] == MAC_NONDATA) begin
        sym[2] = 1'b0;
      end
      line_rx = 3'($random(seed));
      tick(4);
      e = use_line ? line_rx : loop_exp(sym);
      m = msk(e);
      check(ind & m, e & m, "reported symbol");
      check(tx_sym, sym, "internal transmit symbol");
    end
    check({2'h0, ind_n}, 3'h1, "mode indication high");
  endtask

  task automatic close_out;
    $display("Checks %0d, failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of about 75 us.
  initial begin
    #2000000;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    close_out();
  end

  // Main sequence.
  initial begin
    seed = 5;
    failures = 0;
    total_checks = 0;
    rst_n_in = 1'b0;
    hw_reset_in = 1'b0;
    jabber_in = 1'b0;
    mode_n = 1'b1;
    sym = 3'h6;
    line_rx = 3'h6;
    repeat (8) @(posedge ref_clk_in);
    #5;
    rst_n_in = 1'b1;
    check({ind_n, xdis, xen}, 3'h6, "reset mode and transmitter");
    check({lb, i2, i1}, 3'h7, "reset loopback and silence");
    mode_n = 1'b0;
    sym = REQ_DIS_LB;
    tick(1);
    hw_reset_in = 1'b1;
    tick(1);
    hw_reset_in = 1'b0;
    tick(30);
    check({ind_n, lb, xdis}, 3'h7, "commands ignored after release");
    $display("Test done: reset");
    mode_n = 1'b1;
    sym = 3'h6;
    tick(3);
    mac_run(1'b0);
    $display("Test done: loopback");
    enter(REQ_DIS_LB);
    check(ind, {IND_ACK, 1'b1}, "ack loopback off");
    check({lb, xdis, xen}, 3'h2, "loopback off");
    sym = REQ_EN_TX;
    tick(2);
    check(ind, {IND_ACK, 1'b1}, "ack transmitter on");
    check({lb, xdis, xen}, 3'h1, "transmitter on");
    for (i = 0; i < 4; i++) begin
      sym = codes[i];
      tick(3);
      check(ind, IND_IDLE, "idle answer");
    end
    $display("Test done: commands");
    sym = REQ_SERIAL_MGMT_DATA_CMD;
    wait_nack();
    sym = REQ_IDLE;
    check(ind, {IND_NACK, 1'b0}, "start bit");
    for (i = 1; i < 10; i++) begin
      tick(1);
      check(ind, {IND_NACK, i == 9}, "response byte bit");
    end
    tick(1);
    check(ind, IND_IDLE, "idle after byte");
    check({lb, xdis, xen}, 3'h1, "serial data not executed");
    $display("Test done: serial data");
    mode_n = 1'b1;
    sym = 3'h6;
    tick(3);
    mac_run(1'b1);
    $display("Test done: line receive");
    enter(REQ_IDLE);
    sym = REQ_SERIAL_MGMT_DATA_CMD;
    wait_nack();
    jc0 = jc_cnt;
    sym = REQ_RESET;
    tick(3);
    check(ind, {IND_ACK, 1'b1}, "reset aborts byte");
    check({lb, xdis, xen}, 3'h6, "reset command");
    check({2'h0, jc_cnt != jc0}, 3'h1, "jabber timer cleared");
    tick(12);
    check(ind, {IND_ACK, 1'b1}, "byte stays aborted");
    jabber_in = 1'b1;
    tick(3);
    check(ind, IND_PHY_ERR, "jabber error");
    check({2'h0, ind_n}, 3'h0, "error mode indication");
    jabber_in = 1'b0;
    mode_n = 1'b1;
    sym = 3'h6;
    tick(4);
    check({2'h0, ind_n}, 3'h1, "back in MAC mode");
    $display("Test done: abort and jabber");
    close_out();
  end
endmodule
